// ---- verilog/core_map_config.sv ----
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ps
`include "core_map_map.svh"

// How it works
// - Window bases have six zero low bits
// - Window masks have six one low bits
// - Mask ones contiguous from least significant bit
// - Base and mask never share set bit
// - Eight fetch windows, each with enable
// - Eight independent load/store windows
// - Blocks start at multiple of own size
// - Odd sizes align to next power two
// - Blocks never overlap nor cross regions
// - Start is region base plus offset
// - Optional insn memory, 4 to 512 KB
// - Data memory sizes include 48 KB
// - Optional insn cache, 16 to 256 KB
// - Cache protection: zero parity, one ECC
// - Interrupt register block, 32 to 256 KB

module core_map_config
#(
  parameter logic [`WIN_COUNT-1:0]              FETCH_WINDOW_ENABLE     = '0,
  parameter logic [`WIN_COUNT-1:0][`ADDR_W-1:0] FETCH_WINDOW_BASE       = '0,
  parameter logic [`WIN_COUNT-1:0][`ADDR_W-1:0] FETCH_WINDOW_MASK       = '1,
  parameter logic [`WIN_COUNT-1:0]              LOADSTORE_WINDOW_ENABLE = '0,
  parameter logic [`WIN_COUNT-1:0][`ADDR_W-1:0] LOADSTORE_WINDOW_BASE   = '0,
  parameter logic [`WIN_COUNT-1:0][`ADDR_W-1:0] LOADSTORE_WINDOW_MASK   = '1,
  parameter int unsigned                        INSN_MEMORY_PRESENT     = 1,
  parameter int unsigned                        INSN_MEMORY_REGION      = 14,
  parameter int unsigned                        INSN_MEMORY_OFFSET      = 'h000e_0000,
  parameter int unsigned                        INSN_MEMORY_SIZE_KB     = 64,
  parameter int unsigned                        DATA_MEMORY_REGION      = 15,
  parameter int unsigned                        DATA_MEMORY_OFFSET      = 'h0004_0000,
  parameter int unsigned                        DATA_MEMORY_SIZE_KB     = 64,
  parameter int unsigned                        INSN_CACHE_PRESENT      = 1,
  parameter int unsigned                        INSN_CACHE_SIZE_KB      = 16,
  parameter int unsigned                        INSN_CACHE_PROTECTION_SELECT = 0,
  parameter int unsigned                        IRQ_REGS_REGION         = 15,
  parameter int unsigned                        IRQ_REGS_OFFSET         = 'h00c0_0000,
  parameter int unsigned                        IRQ_REGS_SIZE_KB        = 32
)
(
  input  wire logic clk,
  input  wire logic resetn,
  core_map_link.map_end link,
  output logic      fetch_fault,
  output logic      ls_fault
);

  typedef core_map_pkg::addr_t addr_t;

  // ****************************************
  // Block placement
  // ****************************************

  localparam addr_t REGION_SPAN = addr_t'(1) << `REGION_SPAN_BITS;

  // Start addresses: region base plus byte offset
  localparam addr_t IMEM_START = (addr_t'(INSN_MEMORY_REGION) << `REGION_SPAN_BITS)
                                 + addr_t'(INSN_MEMORY_OFFSET);
  localparam addr_t DMEM_START = (addr_t'(DATA_MEMORY_REGION) << `REGION_SPAN_BITS)
                                 + addr_t'(DATA_MEMORY_OFFSET);
  localparam addr_t IRQ_START  = (addr_t'(IRQ_REGS_REGION) << `REGION_SPAN_BITS)
                                 + addr_t'(IRQ_REGS_OFFSET);

  localparam addr_t IMEM_SIZE = addr_t'(INSN_MEMORY_SIZE_KB) << `KB_SHIFT;
  localparam addr_t DMEM_SIZE = addr_t'(DATA_MEMORY_SIZE_KB) << `KB_SHIFT;
  localparam addr_t IRQ_SIZE  = addr_t'(IRQ_REGS_SIZE_KB) << `KB_SHIFT;

  // Alignment granule: size rounded up to a power of two
  localparam addr_t IMEM_ALIGN = core_map_pkg::ceil_pow2(IMEM_SIZE);
  localparam addr_t DMEM_ALIGN = core_map_pkg::ceil_pow2(DMEM_SIZE);
  localparam addr_t IRQ_ALIGN  = core_map_pkg::ceil_pow2(IRQ_SIZE);

  localparam logic IMEM_ON = (INSN_MEMORY_PRESENT == 1);

  // ****************************************
  // Build argument checks
  // ****************************************

  // Value ranges of each build argument
  if (INSN_MEMORY_PRESENT > 1)
    $error("insn memory enable must be 0 or 1");
  if (!(INSN_MEMORY_SIZE_KB inside {4, 8, 16, 32, 64, 128, 256, 512}))
    $error("illegal insn memory size");
  if (!(DATA_MEMORY_SIZE_KB inside {4, 8, 16, 32, 48, 64, 128, 256, 512}))
    $error("illegal data memory size");
  if (INSN_CACHE_PRESENT > 1)
    $error("insn cache enable must be 0 or 1");
  if (!(INSN_CACHE_SIZE_KB inside {16, 32, 64, 128, 256}))
    $error("illegal insn cache size");
  if (INSN_CACHE_PROTECTION_SELECT > 1)
    $error("cache protection select must be 0 or 1");
  if (!(IRQ_REGS_SIZE_KB inside {32, 64, 128, 256}))
    $error("illegal interrupt register block size");
  if ((INSN_MEMORY_REGION >= (1 << `REGION_SEL_BITS))
      || (DATA_MEMORY_REGION >= (1 << `REGION_SEL_BITS))
      || (IRQ_REGS_REGION >= (1 << `REGION_SEL_BITS)))
    $error("region index out of range");

  // Natural alignment of each offset
  if ((addr_t'(INSN_MEMORY_OFFSET) & (IMEM_ALIGN - addr_t'(1))) != '0)
    $error("insn memory offset misaligned");
  if ((addr_t'(DATA_MEMORY_OFFSET) & (DMEM_ALIGN - addr_t'(1))) != '0)
    $error("data memory offset misaligned");
  if ((addr_t'(IRQ_REGS_OFFSET) & (IRQ_ALIGN - addr_t'(1))) != '0)
    $error("interrupt register offset misaligned");

  // Each block stays inside its own region
  if (IMEM_ON && ((INSN_MEMORY_OFFSET >= REGION_SPAN)
      || (addr_t'(INSN_MEMORY_OFFSET) + IMEM_SIZE > REGION_SPAN)))
    $error("insn memory crosses a region boundary");
  if ((DATA_MEMORY_OFFSET >= REGION_SPAN)
      || (addr_t'(DATA_MEMORY_OFFSET) + DMEM_SIZE > REGION_SPAN))
    $error("data memory crosses a region boundary");
  if ((IRQ_REGS_OFFSET >= REGION_SPAN)
      || (addr_t'(IRQ_REGS_OFFSET) + IRQ_SIZE > REGION_SPAN))
    $error("interrupt registers cross a region boundary");

  // Pairwise overlap
  if (IMEM_ON && (IMEM_START < DMEM_START + DMEM_SIZE)
      && (DMEM_START < IMEM_START + IMEM_SIZE))
    $error("insn memory overlaps data memory");
  if (IMEM_ON && (IMEM_START < IRQ_START + IRQ_SIZE)
      && (IRQ_START < IMEM_START + IMEM_SIZE))
    $error("insn memory overlaps interrupt registers");
  if ((DMEM_START < IRQ_START + IRQ_SIZE)
      && (IRQ_START < DMEM_START + DMEM_SIZE))
    $error("data memory overlaps interrupt registers");

  // ****************************************
  // Window banks
  // ****************************************

  logic fetch_allowed;
  logic ls_allowed;

  // Fetch and load/store windows are fully separate banks
  window_bank
  #(
    .ENABLE (FETCH_WINDOW_ENABLE),
    .BASE   (FETCH_WINDOW_BASE),
    .MASK   (FETCH_WINDOW_MASK)
  )
  u_fetch_windows
  (
    .addr    (link.fetch_addr),
    .allowed (fetch_allowed)
  );

  window_bank
  #(
    .ENABLE (LOADSTORE_WINDOW_ENABLE),
    .BASE   (LOADSTORE_WINDOW_BASE),
    .MASK   (LOADSTORE_WINDOW_MASK)
  )
  u_loadstore_windows
  (
    .addr    (link.ls_addr),
    .allowed (ls_allowed)
  );

  // ****************************************
  // Target decode
  // ****************************************

  core_map_pkg::target_t fetch_tgt;
  core_map_pkg::target_t ls_tgt;

  // Fetch reaches only the insn memory or the outside bus
  always_comb
  begin
    if (IMEM_ON && core_map_pkg::block_hit(link.fetch_addr, IMEM_START, IMEM_SIZE))
      fetch_tgt = core_map_pkg::tgt_insn_mem;
    else
      fetch_tgt = core_map_pkg::tgt_ext;
  end

  // Data side: tightly coupled data first, then interrupt registers
  always_comb
  begin
    if (core_map_pkg::block_hit(link.ls_addr, DMEM_START, DMEM_SIZE))
      ls_tgt = core_map_pkg::tgt_data_mem;
    else if (core_map_pkg::block_hit(link.ls_addr, IRQ_START, IRQ_SIZE))
      ls_tgt = core_map_pkg::tgt_irq_regs;
    else
      ls_tgt = core_map_pkg::tgt_ext;
  end

  // ****************************************
  // Registered answers
  // ****************************************

  // Fetch answer one cycle after the request
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      link.fetch_done   <= 1'b0;
      link.fetch_ok     <= 1'b0;
      link.fetch_target <= core_map_pkg::tgt_ext;
      fetch_fault       <= 1'b0;
    end
    else
    begin
      link.fetch_done <= link.fetch_valid;
      fetch_fault     <= link.fetch_valid && !fetch_allowed;
      if (link.fetch_valid)
      begin
        link.fetch_ok     <= fetch_allowed;
        link.fetch_target <= fetch_tgt;
      end
    end
  end

  // Load/store answer one cycle after the request
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      link.ls_done   <= 1'b0;
      link.ls_ok     <= 1'b0;
      link.ls_target <= core_map_pkg::tgt_ext;
      ls_fault       <= 1'b0;
    end
    else
    begin
      link.ls_done <= link.ls_valid;
      ls_fault     <= link.ls_valid && !ls_allowed;
      if (link.ls_valid)
      begin
        link.ls_ok     <= ls_allowed;
        link.ls_target <= ls_tgt;
      end
    end
  end

  // Cache build options, held constant after reset
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      link.cache_present <= 1'b0;
      link.cache_ecc     <= 1'b0;
      link.cache_size_kb <= '0;
    end
    else
    begin
      link.cache_present <= (INSN_CACHE_PRESENT == 1);
      link.cache_ecc     <= (INSN_CACHE_PROTECTION_SELECT == 1);
      link.cache_size_kb <= (INSN_CACHE_PRESENT == 1)
                            ? `KB_FIELD_W'(INSN_CACHE_SIZE_KB) : '0;
    end
  end

endmodule

// ---- verilog/core_map_map.svh ----
`ifndef CORE_MAP_MAP_SVH
`define CORE_MAP_MAP_SVH

// ****************************************
// Address space geometry
// ****************************************
`define ADDR_W            32
`define WIN_COUNT         8
`define WIN_ALIGN_BITS    6
`define REGION_SPAN_BITS  28
`define REGION_SEL_BITS   4
`define KB_SHIFT          10
`define KB_FIELD_W        10

// ****************************************
// Requester register port
// ****************************************
`define HOST_REG_AW       8
`define HOST_REG_ADDR     8'h00
`define HOST_REG_CMD      8'h04
`define HOST_REG_STATUS   8'h08
`define HOST_ADDR_RESET   32'h0000_0000
`define CMD_FETCH_BIT     0
`define CMD_LS_BIT        1
`define ST_BUSY_BIT       0
`define ST_FETCH_OK_BIT   1
`define ST_LS_OK_BIT      2
`define ST_FETCH_DONE_BIT 3
`define ST_LS_DONE_BIT    4
`define ST_CACHE_ON_BIT   5
`define ST_CACHE_ECC_BIT  6
`define ST_FETCH_TGT_LSB  8
`define ST_LS_TGT_LSB     12
`define ST_CACHE_KB_LSB   16

`endif

// ---- verilog/core_map_pkg.sv ----
`include "core_map_map.svh"

package core_map_pkg;

  typedef logic [`ADDR_W-1:0] addr_t;

  // Where an address lands; one-hot
  typedef enum logic [3:0]
  {
    tgt_ext      = 4'h1,
    tgt_insn_mem = 4'h2,
    tgt_data_mem = 4'h4,
    tgt_irq_regs = 4'h8
  } target_t;

  typedef enum logic [1:0]
  {
    st_idle = 2'h1,
    st_wait = 2'h2
  } host_state_t;

  // Window match: mask-selected low bits forced to one on both sides
  function automatic logic window_hit(addr_t addr, addr_t base, addr_t mask);
    return (addr | mask) == (base | mask);
  endfunction

  // Address inside [start, start + size)
  function automatic logic block_hit(addr_t addr, addr_t start, addr_t size);
    return (addr >= start) && ((addr - start) < size);
  endfunction

  // Smallest power of two not below v
  function automatic addr_t ceil_pow2(addr_t v);
    addr_t p;
    p = addr_t'(1);
    for (int i = 0; i < `ADDR_W - 1; i++)
    begin
      if (p < v)
        p = p << 1;
    end
    return p;
  endfunction

endpackage

// ---- verilog/core_map_link.sv ----
`timescale 1ns/1ps
`include "core_map_map.svh"

// ****************************************
// Requester to address map link
// ****************************************
interface core_map_link;
  logic                  fetch_valid;
  core_map_pkg::addr_t   fetch_addr;
  logic                  ls_valid;
  core_map_pkg::addr_t   ls_addr;
  logic                  fetch_done;
  logic                  fetch_ok;
  core_map_pkg::target_t fetch_target;
  logic                  ls_done;
  logic                  ls_ok;
  core_map_pkg::target_t ls_target;
  logic                  cache_present;
  logic                  cache_ecc;
  logic [`KB_FIELD_W-1:0] cache_size_kb;

  modport map_end
  (
    input  fetch_valid, fetch_addr, ls_valid, ls_addr,
    output fetch_done, fetch_ok, fetch_target, ls_done, ls_ok, ls_target,
    output cache_present, cache_ecc, cache_size_kb
  );

  modport requester_end
  (
    output fetch_valid, fetch_addr, ls_valid, ls_addr,
    input  fetch_done, fetch_ok, fetch_target, ls_done, ls_ok, ls_target,
    input  cache_present, cache_ecc, cache_size_kb
  );
endinterface

// ---- verilog/window_bank.sv ----
`timescale 1ns/1ps
`include "core_map_map.svh"

// ****************************************
// Bank of eight protection windows
// ****************************************
module window_bank
#(
  parameter logic [`WIN_COUNT-1:0]             ENABLE = '0,
  parameter logic [`WIN_COUNT-1:0][`ADDR_W-1:0] BASE   = '0,
  parameter logic [`WIN_COUNT-1:0][`ADDR_W-1:0] MASK   = '1
)
(
  input  wire core_map_pkg::addr_t addr,
  output logic                     allowed
);

  localparam core_map_pkg::addr_t LOW_ONES = (`ADDR_W'(1) << `WIN_ALIGN_BITS) - `ADDR_W'(1);

  // Build-time sanity of every window, enabled or not
  for (genvar w = 0; w < `WIN_COUNT; w++)
  begin : g_chk
    if ((BASE[w] & LOW_ONES) != '0)
      $error("window base not on 64-byte boundary");
    if ((MASK[w] & LOW_ONES) != LOW_ONES)
      $error("window mask low six bits not all ones");
    if (((MASK[w] + `ADDR_W'(1)) & MASK[w]) != '0)
      $error("window mask ones not contiguous from bit zero");
    if ((BASE[w] & MASK[w]) != '0)
      $error("window base and mask share a set bit");
  end

  // No window enabled means nothing is fenced off
  always_comb
  begin
    allowed = (ENABLE == '0);
    for (int w = 0; w < `WIN_COUNT; w++)
    begin
      if (ENABLE[w] && core_map_pkg::window_hit(addr, BASE[w], MASK[w]))
        allowed = 1'b1;
    end
  end

endmodule

// ---- verilog/map_requester.sv ----
`timescale 1ns/1ps
`include "core_map_map.svh"

// ****************************************
// Requester: software-driven address probe
// ****************************************
module map_requester
(
  input  wire logic                    clk,
  input  wire logic                    resetn,
  core_map_link.requester_end          link,
  input  wire logic [`HOST_REG_AW-1:0] reg_addr,
  input  wire logic [`ADDR_W-1:0]      reg_wdata,
  input  wire logic                    reg_write,
  input  wire logic                    reg_read,
  output logic      [`ADDR_W-1:0]      reg_rdata
);

  core_map_pkg::host_state_t state_q;
  core_map_pkg::addr_t       probe_addr_q;
  logic                      fetch_done_q;
  logic                      ls_done_q;
  logic                      fetch_ok_q;
  logic                      ls_ok_q;
  core_map_pkg::target_t     fetch_tgt_q;
  core_map_pkg::target_t     ls_tgt_q;
  logic                      fetch_pend_q;
  logic                      ls_pend_q;
  logic                      cmd_go;

  // Commands while a probe is outstanding are dropped
  assign cmd_go = reg_write && (reg_addr == `HOST_REG_CMD) && (state_q == core_map_pkg::st_idle);

  // Probe address register
  always_ff @(posedge clk)
  begin
    if (!resetn)
      probe_addr_q <= `HOST_ADDR_RESET;
    else if (reg_write && (reg_addr == `HOST_REG_ADDR))
      probe_addr_q <= reg_wdata;
  end

  // Request pulses and wait state
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state_q          <= core_map_pkg::st_idle;
      link.fetch_valid <= 1'b0;
      link.ls_valid    <= 1'b0;
      link.fetch_addr  <= '0;
      link.ls_addr     <= '0;
      fetch_pend_q     <= 1'b0;
      ls_pend_q        <= 1'b0;
    end
    else
    begin
      link.fetch_valid <= cmd_go && reg_wdata[`CMD_FETCH_BIT];
      link.ls_valid    <= cmd_go && reg_wdata[`CMD_LS_BIT];
      case (state_q)
        core_map_pkg::st_idle:
        begin
          if (cmd_go && (reg_wdata[`CMD_FETCH_BIT] || reg_wdata[`CMD_LS_BIT]))
          begin
            link.fetch_addr <= probe_addr_q;
            link.ls_addr    <= probe_addr_q;
            fetch_pend_q    <= reg_wdata[`CMD_FETCH_BIT];
            ls_pend_q       <= reg_wdata[`CMD_LS_BIT];
            state_q         <= core_map_pkg::st_wait;
          end
        end
        core_map_pkg::st_wait:
        begin
          // Answers come back together, one cycle after the pulse
          if (link.fetch_done || link.ls_done)
          begin
            fetch_pend_q <= 1'b0;
            ls_pend_q    <= 1'b0;
            state_q      <= core_map_pkg::st_idle;
          end
        end
        default: state_q <= core_map_pkg::st_idle;
      endcase
    end
  end

  // Captured answers; a new command clears the done flags
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      fetch_done_q <= 1'b0;
      ls_done_q    <= 1'b0;
      fetch_ok_q   <= 1'b0;
      ls_ok_q      <= 1'b0;
      fetch_tgt_q  <= core_map_pkg::tgt_ext;
      ls_tgt_q     <= core_map_pkg::tgt_ext;
    end
    else
    begin
      if (link.fetch_done && fetch_pend_q)
      begin
        fetch_done_q <= 1'b1;
        fetch_ok_q   <= link.fetch_ok;
        fetch_tgt_q  <= link.fetch_target;
      end
      else if (cmd_go)
        fetch_done_q <= 1'b0;
      if (link.ls_done && ls_pend_q)
      begin
        ls_done_q <= 1'b1;
        ls_ok_q   <= link.ls_ok;
        ls_tgt_q  <= link.ls_target;
      end
      else if (cmd_go)
        ls_done_q <= 1'b0;
    end
  end

  // Read port: data one cycle after the strobe, zero elsewhere
  always_ff @(posedge clk)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_read && (reg_addr == `HOST_REG_ADDR))
      reg_rdata <= probe_addr_q;
    else if (reg_read && (reg_addr == `HOST_REG_STATUS))
    begin
      reg_rdata                                             <= '0;
      reg_rdata[`ST_BUSY_BIT]                               <= (state_q == core_map_pkg::st_wait);
      reg_rdata[`ST_FETCH_OK_BIT]                           <= fetch_ok_q;
      reg_rdata[`ST_LS_OK_BIT]                              <= ls_ok_q;
      reg_rdata[`ST_FETCH_DONE_BIT]                         <= fetch_done_q;
      reg_rdata[`ST_LS_DONE_BIT]                            <= ls_done_q;
      reg_rdata[`ST_CACHE_ON_BIT]                           <= link.cache_present;
      reg_rdata[`ST_CACHE_ECC_BIT]                          <= link.cache_ecc;
      reg_rdata[`ST_FETCH_TGT_LSB+:4]                       <= fetch_tgt_q;
      reg_rdata[`ST_LS_TGT_LSB+:4]                          <= ls_tgt_q;
      reg_rdata[`ST_CACHE_KB_LSB+:`KB_FIELD_W]              <= link.cache_size_kb;
    end
    else
      reg_rdata <= '0;
  end

endmodule

// ---- testbench/core_map_config_monitor.sv ----
`timescale 1ns/1ps
`include "core_map_map.svh"

// ****************************************
// Link checker
// ****************************************
module core_map_config_monitor
(
  input wire logic                    clk,
  input wire logic                    resetn,
  input wire logic                    fetch_valid,
  input wire core_map_pkg::addr_t     fetch_addr,
  input wire logic                    ls_valid,
  input wire core_map_pkg::addr_t     ls_addr,
  input wire logic                    fetch_done,
  input wire logic                    fetch_ok,
  input wire core_map_pkg::target_t   fetch_target,
  input wire logic                    ls_done,
  input wire logic                    ls_ok,
  input wire core_map_pkg::target_t   ls_target,
  input wire logic                    cache_present,
  input wire logic                    cache_ecc,
  input wire logic [`KB_FIELD_W-1:0]  cache_size_kb,
  input wire logic                    fetch_fault,
  input wire logic                    ls_fault
);
  default clocking dck @(posedge clk); endclocking
  default disable iff (!resetn);

  // Request, then its answer one edge later
  sequence s_fetch_ans;
    fetch_valid ##1 fetch_done;
  endsequence
  sequence s_ls_ans;
    ls_valid ##1 ls_done;
  endsequence

  // Windows and map match the bench build: fetch region 14, ls 64 KB at f004_0000
  AST_FETCH_ANSWER: assert property (fetch_valid |-> s_fetch_ans)
    else $error("fetch answer missing");
  AST_LS_ANSWER: assert property (ls_valid |-> s_ls_ans)
    else $error("load/store answer missing");
  AST_NO_STRAY: assert property (!fetch_valid && !ls_valid |=> !fetch_done && !ls_done)
    else $error("answer without request");
  AST_FETCH_WIN: assert property (fetch_done |->
    fetch_ok == ((fetch_addr | 32'h0fff_ffff) == 32'hefff_ffff))
    else $error("fetch window decision wrong");
  AST_LS_WIN: assert property (ls_done |->
    ls_ok == ((ls_addr | 32'h0000_ffff) == 32'hf004_ffff))
    else $error("load/store window decision wrong");
  AST_FETCH_FAULT: assert property (fetch_fault == (fetch_done && !fetch_ok))
    else $error("fetch fault mismatch");
  AST_LS_FAULT: assert property (ls_fault == (ls_done && !ls_ok))
    else $error("load/store fault mismatch");
  AST_FETCH_TGT: assert property (fetch_done |-> fetch_target ==
    ((fetch_addr[31:16] == 16'he00e) ? core_map_pkg::tgt_insn_mem : core_map_pkg::tgt_ext))
    else $error("fetch target wrong");
  AST_LS_TGT: assert property (ls_done |-> ls_target ==
    ((ls_addr[31:16] == 16'hf004) ? core_map_pkg::tgt_data_mem :
     (ls_addr[31:15] == 17'h1e180) ? core_map_pkg::tgt_irq_regs : core_map_pkg::tgt_ext))
    else $error("load/store target wrong");
  AST_FETCH_HOLD: assert property (!fetch_valid |=>
    $stable(fetch_ok) && $stable(fetch_target))
    else $error("fetch result moved");
  AST_CACHE: assert property ($past(resetn) |->
    cache_present && !cache_ecc && cache_size_kb == 10'h010)
    else $error("cache fields wrong");
endmodule

// ---- testbench/test_core_map_config.sv ----
`timescale 1ns/1ps
`include "core_map_map.svh"

module test_core_map_config;
  logic                    clk;
  logic                    resetn;
  logic [`HOST_REG_AW-1:0] reg_addr;
  logic [`ADDR_W-1:0]      reg_wdata;
  logic                    reg_write;
  logic                    reg_read;
  logic [`ADDR_W-1:0]      reg_rdata;
  logic [`ADDR_W-1:0]      rd;
  logic                    fetch_fault;
  logic                    ls_fault;
  int                      err_total = 0;
  int                      cmp_count = 0;
  int                      cycles = 0;
  logic [41:0]             tbl [9];

  core_map_link core_map_link_i ();
  // Fetch window 0 covers region 14; load/store window 7 covers data memory only
  core_map_config #(.FETCH_WINDOW_ENABLE(8'h01),
    .FETCH_WINDOW_BASE({224'h0, 32'he000_0000}),
    .FETCH_WINDOW_MASK({{7{32'hffff_ffff}}, 32'h0fff_ffff}),
    .LOADSTORE_WINDOW_ENABLE(8'h80), .LOADSTORE_WINDOW_BASE({32'hf004_0000, 224'h0}),
    .LOADSTORE_WINDOW_MASK({32'h0000_ffff, {7{32'hffff_ffff}}}),
    // Offsets naturally aligned, blocks disjoint and each inside its region
    .INSN_MEMORY_OFFSET(32'h000e_0000), .DATA_MEMORY_OFFSET(32'h0004_0000),
    .IRQ_REGS_OFFSET(32'h00c0_0000)) core_map_config_i (.clk(clk),
    .resetn(resetn), .link(core_map_link_i), .fetch_fault(fetch_fault), .ls_fault(ls_fault));
  map_requester map_requester_i (.clk(clk), .resetn(resetn), .link(core_map_link_i),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  core_map_config_monitor core_map_config_monitor_i (.clk(clk), .resetn(resetn),
    .fetch_valid(core_map_link_i.fetch_valid), .fetch_addr(core_map_link_i.fetch_addr),
    .ls_valid(core_map_link_i.ls_valid), .ls_addr(core_map_link_i.ls_addr),
    .fetch_done(core_map_link_i.fetch_done), .fetch_ok(core_map_link_i.fetch_ok),
    .fetch_target(core_map_link_i.fetch_target), .ls_done(core_map_link_i.ls_done),
    .ls_ok(core_map_link_i.ls_ok), .ls_target(core_map_link_i.ls_target),
    .cache_present(core_map_link_i.cache_present), .cache_ecc(core_map_link_i.cache_ecc),
    .cache_size_kb(core_map_link_i.cache_size_kb), .fetch_fault(fetch_fault),
    .ls_fault(ls_fault));

  // ****************************************
  // Register port tasks
  // ****************************************
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    $display("mismatches %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Probe one address; status polled, bounded, until not busy
  task automatic probe(input logic [41:0] e, input logic [31:0] cmd);
    logic [31:0] st;
    reg_wr(`HOST_REG_ADDR, e[41:10]);
    reg_wr(`HOST_REG_CMD, cmd);
    for (int i = 0; i < 8; i++)
    begin
      reg_rd(`HOST_REG_STATUS, st);
      if (st[0] === 1'b0)
        break;
    end
    check(st, {6'h0, 10'h010, e[3:0], e[8:5], 3'h1, cmd[1], cmd[0], e[4], e[9], 1'b0});
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      close_out();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    // Address, fetch {ok, target}, load/store {ok, target}
    tbl = '{{32'he00e_0000, 5'h12, 5'h01}, {32'he00e_fffc, 5'h12, 5'h01},
      {32'he00f_0000, 5'h11, 5'h01}, {32'hdfff_ffc0, 5'h01, 5'h01},
      {32'hf004_0000, 5'h01, 5'h14}, {32'hf004_fffc, 5'h01, 5'h14},
      {32'hf005_0000, 5'h01, 5'h01}, {32'hf0c0_7ffc, 5'h01, 5'h08},
      {32'hf0c0_8000, 5'h01, 5'h01}};
    resetn    = 1'b0;
    reg_addr  = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    foreach (tbl[i]) probe(tbl[i], 32'h3);
    // One-sided probes with a two-sided one between: the idle side's done flag clears, its ok and target stay in status
    probe(tbl[4], 32'h2);
    probe(tbl[8], 32'h3);
    probe(tbl[0], 32'h1);
    reg_rd(8'h0c, rd);
    check(rd, 32'h0);
    close_out();
  end
endmodule
